//--- core/wdc_watchdog.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// watchdog with avalon register slave
// ----------------------------------------------------------------
module wdc_watchdog #(
  parameter int TICK_CYCLES = wdc_pkg::TICK_CYC
) (
  input wire logic clk, // core clock, 40 MHz
  input wire logic srst, // hardware reset, sync, high
  input wire logic [3:0] avs_address, // byte address
  input wire logic [3:0] avs_byteenable, // byte lanes
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall request
  input wire logic supply_monitor, // supply alarm level
  output logic sys_reset_req, // one-cycle reset request
  output logic irq // level interrupt
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    wdc_pkg::wdc_bus_t phase;
    logic [31:0] rdata;
    logic [wdc_pkg::PRE_W-1:0] pre;
    logic sel;
    logic flag;
    logic en;
    logic armed;
    logic restart;
    logic rst_req;
    logic [wdc_pkg::EV_W-1:0] sts;
    logic [wdc_pkg::EV_W-1:0] ien;
  } wdc_st_t;

  wdc_st_t st_r;
  wdc_st_t st_nxt;

  logic req;
  logic acc;
  logic wr;
  logic hit_ctl;
  logic ctl_acc;
  logic ctl_arm;
  logic ctl_ref;
  logic tick;
  logic cnt_expire;
  logic [31:0] rd_val;
  logic [wdc_pkg::EV_W-1:0] wr_ev;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------

  // one wait cycle, then the access completes
  assign req = avs_read || avs_write;
  assign avs_waitrequest = req && (st_r.phase == wdc_pkg::BUS_IDLE);
  assign acc = req && (st_r.phase == wdc_pkg::BUS_DONE);
  assign wr = acc && avs_write && avs_byteenable[0];
  assign hit_ctl = (avs_address == wdc_pkg::OFF_CTL);
  assign wr_ev = avs_writedata[wdc_pkg::EV_W-1:0];

  // unlock sequence: arm, then the very next access may write
  assign ctl_acc = wr && hit_ctl && st_r.armed;
  assign ctl_arm = wr && hit_ctl && !st_r.armed
    && avs_writedata[wdc_pkg::B_UNLOCK];
  assign ctl_ref = wr && hit_ctl && !st_r.armed
    && !avs_writedata[wdc_pkg::B_UNLOCK];

  // read value multiplexer
  always_comb begin
    rd_val = '0;
    case (avs_address)
      wdc_pkg::OFF_CTL: begin
        rd_val[wdc_pkg::B_PRE +: wdc_pkg::PRE_W] = st_r.pre;
        rd_val[wdc_pkg::B_SEL] = st_r.sel;
        rd_val[wdc_pkg::B_FLAG] = st_r.flag;
        rd_val[wdc_pkg::B_EN] = st_r.en;
        rd_val[wdc_pkg::B_UNLOCK] = st_r.armed;
      end
      wdc_pkg::OFF_STS: begin
        rd_val[wdc_pkg::EV_W-1:0] = st_r.sts;
      end
      wdc_pkg::OFF_IEN: begin
        rd_val[wdc_pkg::EV_W-1:0] = st_r.ien;
      end
      default: begin
        rd_val = '0; // clear register and holes read zero
      end
    endcase
  end

  // ----------------------------------------------------------------
  // timing path
  // ----------------------------------------------------------------

  // base tick, restarted together with the counter
  wdc_tick_div #(
    .DIV(TICK_CYCLES)
  ) u_div (
    .clk(clk),
    .srst(srst),
    .run(st_r.en),
    .restart(st_r.restart),
    .tick(tick)
  );

  // prescaled period counter
  wdc_timeout_cnt u_cnt (
    .clk(clk),
    .srst(srst),
    .run(st_r.en),
    .restart(st_r.restart),
    .tick(tick),
    .pre(st_r.pre),
    .expire(cnt_expire)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.restart = 1'b0;
    st_nxt.rst_req = 1'b0;

    // bus phase and registered read data
    case (st_r.phase)
      wdc_pkg::BUS_IDLE: begin
        if (req) begin
          st_nxt.phase = wdc_pkg::BUS_DONE;
          st_nxt.rdata = rd_val;
        end
      end
      wdc_pkg::BUS_DONE: begin
        st_nxt.phase = wdc_pkg::BUS_IDLE;
      end
      default: begin
        st_nxt.phase = wdc_pkg::BUS_IDLE;
      end
    endcase

    // any completed access closes the unlock window
    if (acc) begin
      st_nxt.armed = ctl_arm;
    end

    // accepted control write
    if (ctl_acc) begin
      st_nxt.pre = avs_writedata[wdc_pkg::B_PRE +: wdc_pkg::PRE_W];
      st_nxt.sel = avs_writedata[wdc_pkg::B_SEL];
      st_nxt.en = avs_writedata[wdc_pkg::B_EN];
      st_nxt.restart = avs_writedata[wdc_pkg::B_EN];
      if (!avs_writedata[wdc_pkg::B_FLAG]) begin
        st_nxt.flag = 1'b0;
      end
    end

    // interrupt enable and clear registers
    if (wr && avs_address == wdc_pkg::OFF_IEN) begin
      st_nxt.ien = wr_ev;
    end
    if (wr && avs_address == wdc_pkg::OFF_CLR) begin
      st_nxt.sts = st_r.sts & ~wr_ev;
    end

    // refused control write is reported
    if (ctl_ref) begin
      st_nxt.sts[wdc_pkg::EV_REF] = 1'b1;
    end

    // supply alarm stops the watchdog
    if (supply_monitor) begin
      st_nxt.en = 1'b0;
    end

    // timeout: hardware set wins over any clear
    if (cnt_expire) begin
      st_nxt.flag = 1'b1;
      st_nxt.sts[wdc_pkg::EV_TO] = 1'b1;
      if (!st_r.sel) begin
        st_nxt.rst_req = 1'b1;
        st_nxt.en = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------

  // flag is kept by anything but the hardware reset or an accepted zero write
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
      st_r.pre <= wdc_pkg::PRE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign avs_readdata = st_r.rdata;
  assign sys_reset_req = st_r.rst_req;
  assign irq = |(st_r.sts & st_r.ien);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking wdc_cb @(posedge clk);
  endclocking
  default disable iff (srst);

  // setting the enable restarts the counters
  restart_on_set_a: assert property (
    ctl_acc && avs_writedata[wdc_pkg::B_EN] && !supply_monitor
    |=> st_r.restart && st_r.en ##1 !st_r.restart
  ) else $error("enable write did not restart watchdog");

  // reset mode timeout requests a system reset
  reset_on_timeout_a: assert property (
    cnt_expire && !st_r.sel |=> sys_reset_req ##1 !sys_reset_req
  ) else $error("reset mode timeout gave no reset request");

  // interrupt mode keeps running as a timer
  timer_mode_a: assert property (
    cnt_expire && st_r.sel && st_r.en && !ctl_acc && !supply_monitor
    |=> st_r.en && !sys_reset_req && st_r.sts[wdc_pkg::EV_TO]
  ) else $error("interrupt mode timeout misbehaved");

  // flag follows a timeout
  flag_set_a: assert property (
    cnt_expire |=> st_r.flag
  ) else $error("timeout did not set flag");

  // flag only falls on a zero write
  flag_keep_a: assert property (
    st_r.flag && !(ctl_acc && !avs_writedata[wdc_pkg::B_FLAG])
    |=> st_r.flag
  ) else $error("flag cleared without zero write");

  // enable falls on supply alarm or reset mode timeout
  enable_drop_a: assert property (
    supply_monitor || (cnt_expire && !st_r.sel) |=> !st_r.en
  ) else $error("enable not cleared");

  // locked writes leave the control fields alone
  locked_write_a: assert property (
    wr && hit_ctl && !st_r.armed
    |=> $stable(st_r.pre) && $stable(st_r.sel) && st_r.armed == $past(
      avs_writedata[wdc_pkg::B_UNLOCK])
  ) else $error("control changed without unlock");

  // ----------------------------------------------------------------
  // cause and effect checks
  // ----------------------------------------------------------------

  // a restart pulse only follows an accepted enable write
  restart_cause_a: assert property (
    st_r.restart |-> $past(ctl_acc) && $past(avs_writedata[wdc_pkg::B_EN])
  ) else $error("restart without enable write");

  // a reset request only follows a reset mode timeout
  reset_cause_a: assert property (
    sys_reset_req |-> $past(cnt_expire) && !$past(st_r.sel)
  ) else $error("reset request without timeout");

  // the reset request is a single cycle pulse
  reset_pulse_a: assert property (
    sys_reset_req |=> !sys_reset_req
  ) else $error("reset request longer than one cycle");

  // the flag only rises on a timeout
  flag_cause_a: assert property (
    $rose(st_r.flag) |-> $past(cnt_expire)
  ) else $error("flag set without timeout");

  // a zero written to the flag clears it unless a timeout lands
  flag_clear_a: assert property (
    ctl_acc && !avs_writedata[wdc_pkg::B_FLAG] && !cnt_expire |=> !st_r.flag
  ) else $error("flag not cleared by zero write");

  // an accepted zero write drops the enable
  enable_clear_a: assert property (
    ctl_acc && !avs_writedata[wdc_pkg::B_EN] |=> !st_r.en
  ) else $error("enable not cleared by zero write");

  // a stopped watchdog never times out
  idle_quiet_a: assert property (
    !st_r.en |=> !cnt_expire
  ) else $error("timeout while disabled");

  // the enable only rises through an unlocked control write
  enable_gate_a: assert property (
    $rose(st_r.en) |-> $past(ctl_acc)
  ) else $error("enable set without unlock");

  // the unlock window closes after one access
  unlock_once_a: assert property (
    st_r.armed && acc |=> !st_r.armed
  ) else $error("unlock window left open");

  // a refused control write is flagged in status
  refuse_flag_a: assert property (
    ctl_ref |=> st_r.sts[wdc_pkg::EV_REF]
  ) else $error("refused control write not flagged");

  // an enabled timeout raises the interrupt
  timer_irq_a: assert property (
    cnt_expire && st_r.ien[wdc_pkg::EV_TO]
    && !(wr && avs_address == wdc_pkg::OFF_IEN) |=> irq
  ) else $error("timeout gave no interrupt");

  // a timeout status bit stays until cleared
  sts_sticky_a: assert property (
    st_r.sts[wdc_pkg::EV_TO]
    && !(wr && avs_address == wdc_pkg::OFF_CLR && avs_writedata[wdc_pkg::EV_TO])
    |=> st_r.sts[wdc_pkg::EV_TO]
  ) else $error("timeout status lost");

  // an accepted write loads the prescaler
  pre_load_a: assert property (
    ctl_acc |=> st_r.pre == $past(avs_writedata[wdc_pkg::B_PRE +: wdc_pkg::PRE_W])
  ) else $error("prescaler not loaded");

  // main scenarios
  enable_cov: cover property (ctl_acc && avs_writedata[wdc_pkg::B_EN]);
  reset_cov: cover property (cnt_expire && !st_r.sel);
  timer_cov: cover property (cnt_expire && st_r.sel ##1 irq);
  refused_cov: cover property (ctl_ref);
  supply_cov: cover property (supply_monitor && st_r.en);
endmodule : wdc_watchdog

//--- inc/wdc_pkg.sv
// ----------------------------------------------------------------
// watchdog constants
// ----------------------------------------------------------------
package wdc_pkg;
  // clock and base tick timing
  localparam int CLK_NS = 25;
  localparam int TICK_NS = 1000000; // base tick of 1 ms
  localparam int TICK_CYC = TICK_NS / CLK_NS;

  // register byte offsets
  localparam logic [3:0] OFF_CTL = 4'h0;
  localparam logic [3:0] OFF_STS = 4'h4;
  localparam logic [3:0] OFF_CLR = 4'h8;
  localparam logic [3:0] OFF_IEN = 4'hc;

  // control register fields
  localparam int B_UNLOCK = 0;
  localparam int B_EN = 1;
  localparam int B_FLAG = 2;
  localparam int B_SEL = 3;
  localparam int B_PRE = 4;
  localparam int PRE_W = 4;
  localparam logic [PRE_W-1:0] PRE_RST = 4'h0;

  // event bits of status, clear and enable registers
  localparam int EV_W = 2;
  localparam int EV_TO = 0;
  localparam int EV_REF = 1;

  // timeout counter width, holds up to 2^15 ticks
  localparam int CNT_W = 16;

  // bus answer phase
  typedef enum logic {BUS_IDLE, BUS_DONE} wdc_bus_t;
endpackage : wdc_pkg

//--- core/wdc_tick_div.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// base tick divider
// ----------------------------------------------------------------
module wdc_tick_div #(
  parameter int DIV = wdc_pkg::TICK_CYC
) (
  input wire logic clk, // core clock
  input wire logic srst, // sync reset
  input wire logic run, // count while high
  input wire logic restart, // zero the phase
  output logic tick // one-cycle base tick
);
  localparam int W = $clog2(DIV + 1);
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } wdc_div_st_t;

  wdc_div_st_t st_r;
  wdc_div_st_t st_nxt;

  // divide the core clock down to the base tick
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (!run || restart) begin
      st_nxt.cnt = '0;
    end else if (st_r.cnt == LAST) begin
      st_nxt.cnt = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + W'(1);
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;
endmodule : wdc_tick_div

//--- core/wdc_timeout_cnt.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// prescaled timeout counter
// ----------------------------------------------------------------
module wdc_timeout_cnt (
  input wire logic clk, // core clock
  input wire logic srst, // sync reset
  input wire logic run, // watchdog enabled
  input wire logic restart, // start a new period
  input wire logic tick, // base tick pulse
  input wire logic [wdc_pkg::PRE_W-1:0] pre, // period is 2^pre ticks
  output logic expire // one-cycle timeout pulse
);
  typedef struct packed {
    logic [wdc_pkg::CNT_W-1:0] cnt;
    logic expire;
  } wdc_cnt_st_t;

  wdc_cnt_st_t st_r;
  wdc_cnt_st_t st_nxt;
  logic [wdc_pkg::CNT_W:0] lim;
  logic [wdc_pkg::CNT_W-1:0] last;

  // last tick count of the period
  assign lim = (wdc_pkg::CNT_W + 1)'(1) << pre;
  assign last = wdc_pkg::CNT_W'(lim - (wdc_pkg::CNT_W + 1)'(1));

  // count ticks, wrap and pulse at the end of a period
  always_comb begin
    st_nxt = st_r;
    st_nxt.expire = 1'b0;
    if (!run || restart) begin
      st_nxt.cnt = '0;
    end else if (tick) begin
      if (st_r.cnt == last) begin
        st_nxt.cnt = '0;
        st_nxt.expire = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + wdc_pkg::CNT_W'(1);
      end
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign expire = st_r.expire;

  // expiry only at the prescaled count
  period_end_a: assert property (
    @(posedge clk) disable iff (srst)
    st_r.expire |-> $past(st_r.cnt) == $past(last) && $past(tick)
  ) else $error("timeout not at prescaled count");
endmodule : wdc_timeout_cnt

//--- test/wdc_cpu_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// avalon master standing in for the processor core
// ----------------------------------------------------------------
module wdc_cpu_model (
  input wire logic clk, // core clock
  input wire logic waitreq, // slave stall
  output logic [3:0] addr, // byte address
  output logic rd, // read request
  output logic wr, // write request
  output logic [31:0] wdata // write data
);
  // one access, held until waitrequest is sampled low, then released
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= {24'h0, d};
    wr <= w;
    rd <= !w;
    @(posedge clk);
    while (waitreq) @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    wdata <= ~wdata; // released data no longer holds its value
    @(posedge clk);
  endtask : acc

  // idle bus at time zero
  initial begin
    rd = 1'b0;
    wr = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
  end
endmodule : wdc_cpu_model

//--- test/wdc_watchdog_tb.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// watchdog bench
// ----------------------------------------------------------------
module wdc_watchdog_tb;
  logic clk;
  logic srst;
  logic supply_monitor;
  logic [3:0] addr;
  logic rd;
  logic wr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic waitreq;
  logic sys_reset_req;
  logic irq;
  logic [31:0] exp_q[$];
  int n_mismatch = 0;
  int checks_done = 0;
  int n_rst = 0;
  int cyc = 0;
  int i;

  // design with short base tick
  wdc_watchdog #(.TICK_CYCLES(4)) uut (
    .clk(clk), .srst(srst), .avs_address(addr), .avs_byteenable(4'h1),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_readdata(rdata),
    .avs_waitrequest(waitreq), .supply_monitor(supply_monitor),
    .sys_reset_req(sys_reset_req), .irq(irq)
  );

  // processor core model
  wdc_cpu_model cpu (
    .clk(clk), .waitreq(waitreq), .addr(addr), .rd(rd), .wr(wr), .wdata(wdata)
  );

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  // read with expected value noted for the monitor
  task automatic rdx(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    cpu.acc(1'b0, a, 8'h0);
  endtask : rdx

  // unlock then write control
  task automatic ctl(input logic [7:0] d);
    cpu.acc(1'b1, 4'h0, 8'h01);
    cpu.acc(1'b1, 4'h0, d);
  endtask : ctl

  task automatic wait_irq();
    for (i = 0; i < 300 && irq !== 1'b1; i++) @(posedge clk);
  endtask : wait_irq

  // timeout: a hang counts as a mismatch and ends the run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // monitor: read results against queued notes, reset pulses
  always @(posedge clk) begin
    if (sys_reset_req === 1'b1) n_rst++;
    if (rd && waitreq === 1'b0 && exp_q.size() > 0) begin
      chk(rdata, exp_q.pop_front());
    end
  end

  // main sequence
  initial begin
    srst = 1'b1;
    supply_monitor = 1'b0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    void'($urandom(97));
    rdx(4'h0, 32'h0);
    rdx(4'h4, 32'h0);
    rdx(4'hc, 32'h0);
    cpu.acc(1'b1, 4'h6, 8'hff);
    rdx(4'h6, 32'h0);
    // control write without unlock is refused
    cpu.acc(1'b1, 4'h0, 8'h02);
    rdx(4'h0, 32'h0);
    rdx(4'h4, 32'h2);
    cpu.acc(1'b1, 4'h8, 8'h02);
    rdx(4'h4, 32'h0);
    // interrupt mode, periodic timer
    ctl(8'h4a);
    cpu.acc(1'b1, 4'hc, 8'h01);
    rdx(4'h0, 32'h4a);
    wait_irq();
    chk(irq, 1'b1);
    rdx(4'h0, 32'h4e);
    rdx(4'h4, 32'h1);
    cpu.acc(1'b1, 4'h8, 8'h01);
    chk(irq, 1'b0);
    wait_irq();
    chk(irq, 1'b1);
    ctl(8'h4a);
    rdx(4'h0, 32'h4a);
    cpu.acc(1'b1, 4'hc, 8'h00);
    chk(irq, 1'b0);
    cpu.acc(1'b1, 4'h8, 8'h03);
    // reset mode: kicks keep it quiet, then it fires
    ctl(8'h32);
    repeat (3) begin
      repeat (15) @(posedge clk);
      ctl(8'h32);
    end
    chk(n_rst, 0);
    // 2^3 ticks of 4 cycles, plus tick, expire and request registers
    for (i = 0; i < 100 && sys_reset_req !== 1'b1; i++) @(posedge clk);
    chk(i, 4 * 8 + 3);
    @(posedge clk);
    chk(n_rst, 1);
    rdx(4'h0, 32'h34);
    // a one written to the flag keeps it
    ctl(8'h34);
    rdx(4'h0, 32'h34);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rdx(4'h0, 32'h0);
    // supply alarm drops the enable
    ctl(8'h32);
    supply_monitor <= 1'b1;
    @(posedge clk);
    supply_monitor <= 1'b0;
    rdx(4'h0, 32'h30);
    // random refused control write leaves control alone
    cpu.acc(1'b1, 4'h0, 8'($urandom()) & 8'hfe);
    rdx(4'h0, 32'h30);
    rdx(4'h4, 32'h2);
    ctl(8'h00);
    rdx(4'h0, 32'h0);
    repeat (4) @(posedge clk);
    chk(n_rst, 1);
    chk(exp_q.size(), 0);
    report_and_stop();
  end
endmodule : wdc_watchdog_tb
